/* core/tpl_loop_ctrl.sv */
// Loop control: APB registers, PI loop filter, DAC and feedback modulators,
// reference pre-divider. Runs on ref_clk_i; pins synchronised.
`timescale 1ns/100ps
`default_nettype none
module tpl_loop_ctrl (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        phase_up_i,
	input  wire logic        phase_down_i,
	input  wire logic        xo_clk_i,
	input  wire logic        ref_in_clk_i,
	output logic             converter_enable_o,
	output logic             dac_bit_o,
	output logic [7:0]       feedback_ratio_o,
	output logic             divided_ref_o
);
	// Configuration registers
	logic        cen_r, cen_nxt;
	logic [4:0]  kp_r, kp_nxt, ki_r, ki_nxt;
	logic [1:0]  fl_r, fl_nxt, dord_r, dord_nxt;
	logic [15:0] frac_r, frac_nxt;
	logic [7:0]  int_r, int_nxt;
	logic        fben_r, fben_nxt;
	logic [1:0]  ford_r, ford_nxt;
	logic [2:0]  rdiv_r, rdiv_nxt;
	logic        swrst_r, swrst_nxt, src_r, src_nxt;
	logic signed [15:0] filt_r;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, perr_r, perr_nxt;
	logic        wr, rd, hit;

	// Single wait state: answer one cycle into the access phase
	always_comb begin
		wr = psel_i & penable_i & pwrite_i & ~pready_r;
		rd = psel_i & penable_i & ~pwrite_i & ~pready_r;
		hit = (paddr_i == tpl_pkg::ADDR_CFG) | (paddr_i == tpl_pkg::ADDR_FRAC)
			| (paddr_i == tpl_pkg::ADDR_INT) | (paddr_i == tpl_pkg::ADDR_FBMOD)
			| (paddr_i == tpl_pkg::ADDR_REFDIV) | (paddr_i == tpl_pkg::ADDR_FILT)
			| (paddr_i == tpl_pkg::ADDR_CTRL);
		cen_nxt = cen_r;
		kp_nxt = kp_r;
		ki_nxt = ki_r;
		fl_nxt = fl_r;
		dord_nxt = dord_r;
		frac_nxt = frac_r;
		int_nxt = int_r;
		fben_nxt = fben_r;
		ford_nxt = ford_r;
		rdiv_nxt = rdiv_r;
		swrst_nxt = swrst_r;
		src_nxt = src_r;
		prdata_nxt = prdata_r;
		pready_nxt = psel_i & penable_i & ~pready_r;
		perr_nxt = psel_i & penable_i & ~pready_r & ~hit;
		if (wr) begin
			unique case (paddr_i)
				tpl_pkg::ADDR_CFG: begin
					cen_nxt = pwdata_i[tpl_pkg::CFG_EN_BIT];
					kp_nxt = pwdata_i[tpl_pkg::KP_LSB +: 5];
					ki_nxt = pwdata_i[tpl_pkg::KI_LSB +: 5];
					fl_nxt = pwdata_i[tpl_pkg::FL_LSB +: 2];
					dord_nxt = pwdata_i[tpl_pkg::DORD_LSB +: 2];
				end
				tpl_pkg::ADDR_FRAC: frac_nxt = pwdata_i[15:0];
				tpl_pkg::ADDR_INT: int_nxt = pwdata_i[7:0];
				tpl_pkg::ADDR_FBMOD: begin
					fben_nxt = pwdata_i[tpl_pkg::FBMOD_EN_BIT];
					ford_nxt = pwdata_i[1:0];
				end
				tpl_pkg::ADDR_REFDIV: rdiv_nxt = pwdata_i[2:0];
				tpl_pkg::ADDR_CTRL: begin
					swrst_nxt = pwdata_i[tpl_pkg::CTRL_RST_BIT];
					src_nxt = pwdata_i[tpl_pkg::CTRL_SRC_BIT];
				end
				default: ;
			endcase
		end
		if (rd) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr_i)
				tpl_pkg::ADDR_CFG:
					prdata_nxt[15:0] = {cen_r, 1'b0, kp_r, ki_r, fl_r, dord_r};
				tpl_pkg::ADDR_FRAC: prdata_nxt[15:0] = frac_r;
				tpl_pkg::ADDR_INT: prdata_nxt[7:0] = int_r;
				tpl_pkg::ADDR_FBMOD: prdata_nxt[7:0] = {fben_r, 5'h00, ford_r};
				tpl_pkg::ADDR_REFDIV: prdata_nxt[2:0] = rdiv_r;
				tpl_pkg::ADDR_FILT: prdata_nxt[15:0] = filt_r;
				tpl_pkg::ADDR_CTRL: prdata_nxt[1:0] = {src_r, swrst_r};
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cen_r <= 1'b0;
			kp_r <= tpl_pkg::KP_RST;
			ki_r <= tpl_pkg::KI_RST;
			fl_r <= tpl_pkg::FL_RST;
			dord_r <= tpl_pkg::DORD_RST;
			frac_r <= tpl_pkg::FRAC_RST;
			int_r <= tpl_pkg::INT_RST;
			fben_r <= tpl_pkg::FBEN_RST;
			ford_r <= tpl_pkg::FBORD_RST;
			rdiv_r <= tpl_pkg::REFDIV_RST;
			swrst_r <= tpl_pkg::SWRST_RST;
			src_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			perr_r <= 1'b0;
		end else begin
			cen_r <= cen_nxt;
			kp_r <= kp_nxt;
			ki_r <= ki_nxt;
			fl_r <= fl_nxt;
			dord_r <= dord_nxt;
			frac_r <= frac_nxt;
			int_r <= int_nxt;
			fben_r <= fben_nxt;
			ford_r <= ford_nxt;
			rdiv_r <= rdiv_nxt;
			swrst_r <= swrst_nxt;
			src_r <= src_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			perr_r <= perr_nxt;
		end
	end

	// Pin synchronisers, three stages; change taken when stages 2 and 3 agree
	logic [3:0] s1_r, s2_r, s3_r, sv_r, s_nxt;
	logic [3:0] pins;
	assign pins = {ref_in_clk_i, xo_clk_i, phase_down_i, phase_up_i};
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			s_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : sv_r[i];
		end
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			sv_r <= 4'h0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sv_r <= s_nxt;
		end
	end

	// PI loop filter
	logic signed [15:0] filt_nxt, integ_r, integ_nxt;
	logic signed [1:0]  err;
	logic        railed_r, railed_nxt;
	logic [5:0]  ki_eff;
	logic [2:0]  prev_r, prev_nxt;
	always_comb begin
		// Error is +1, -1 or 0; railed when the error is nonzero, in either direction, three times running
		err = (sv_r[0] & ~sv_r[1]) ? 2'sb01 : ((sv_r[1] & ~sv_r[0]) ? -2'sd1 : 2'sd0);
		prev_nxt = {prev_r[1:0], sv_r[0] ^ sv_r[1]};
		railed_nxt = &prev_r;
		ki_eff = {1'b0, ki_r} + {3'b000, fl_r, 1'b0};
		if (!railed_r) begin
			ki_eff = {1'b0, ki_r};
		end
		// Shifts of 15 and up are clamped to 14 for the 16-bit path
		integ_nxt = integ_r + ((ki_eff > 6'd14) ? 16'(err) <<< 14 : 16'(err) <<< ki_eff);
		filt_nxt = integ_r + ((kp_r > 5'd14) ? 16'(err) <<< 14 : 16'(err) <<< kp_r);
		if (swrst_r) begin
			integ_nxt = 16'sh0000;
			filt_nxt = 16'sh0000;
			prev_nxt = 3'h0;
		end
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			integ_r <= 16'sh0000;
			filt_r <= 16'sh0000;
			prev_r <= 3'h0;
			railed_r <= 1'b0;
		end else begin
			integ_r <= integ_nxt;
			filt_r <= filt_nxt;
			prev_r <= prev_nxt;
			railed_r <= railed_nxt;
		end
	end

	// DAC modulator and feedback modulator
	logic [16:0] d1_r, d1_nxt, d2_r, d2_nxt;
	logic        dac_r, dac_nxt;
	logic [16:0] f1_r, f1_nxt, f2_r, f2_nxt, f3_r, f3_nxt;
	logic [7:0]  ratio_r, ratio_nxt;
	logic [1:0]  carry;
	always_comb begin
		d1_nxt = {1'b0, d1_r[15:0]} + {1'b0, filt_r ^ 16'h8000};
		d2_nxt = {1'b0, d2_r[15:0]} + {1'b0, d1_nxt[15:0]};
		unique case (dord_r)
			2'h0: dac_nxt = filt_r[15] == 1'b0;
			2'h1: dac_nxt = d1_nxt[16];
			2'h2: dac_nxt = d2_nxt[16];
			default: dac_nxt = 1'b0;
		endcase
		f1_nxt = {1'b0, f1_r[15:0]} + {1'b0, frac_r};
		f2_nxt = {1'b0, f2_r[15:0]} + {1'b0, f1_nxt[15:0]};
		f3_nxt = {1'b0, f3_r[15:0]} + {1'b0, f2_nxt[15:0]};
		unique case (ford_r)
			2'h0: carry = 2'h0;
			2'h1: carry = {1'b0, f1_nxt[16]};
			2'h2: carry = {1'b0, f2_nxt[16]} + {1'b0, f1_nxt[16]};
			default: carry = {1'b0, f3_nxt[16]} + {1'b0, f2_nxt[16]};
		endcase
		ratio_nxt = fben_r ? int_r + {6'h00, carry} : int_r;
		if (swrst_r) begin
			d1_nxt = 17'h0;
			d2_nxt = 17'h0;
		end
		// Feedback enable only stops the divider modulator, never the DAC path
		if (swrst_r || !fben_r) begin
			f1_nxt = 17'h0;
			f2_nxt = 17'h0;
			f3_nxt = 17'h0;
		end
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			d1_r <= 17'h0;
			d2_r <= 17'h0;
			dac_r <= 1'b0;
			f1_r <= 17'h0;
			f2_r <= 17'h0;
			f3_r <= 17'h0;
			ratio_r <= tpl_pkg::INT_RST;
		end else begin
			d1_r <= d1_nxt;
			d2_r <= d2_nxt;
			dac_r <= dac_nxt;
			f1_r <= f1_nxt;
			f2_r <= f2_nxt;
			f3_r <= f3_nxt;
			ratio_r <= ratio_nxt;
		end
	end

	// Reference pre-divider on the synchronised source level
	logic       srcv, srcp_r, srcp_nxt, dref_r, dref_nxt;
	logic [3:0] rcnt_r, rcnt_nxt;
	always_comb begin
		srcv = src_r ? sv_r[3] : sv_r[2];
		srcp_nxt = srcv;
		rcnt_nxt = rcnt_r;
		dref_nxt = dref_r;
		if (rdiv_r == 3'h0) begin
			dref_nxt = srcv;
		end else if (srcv & ~srcp_r) begin
			rcnt_nxt = rcnt_r + 4'h1;
			unique case (rdiv_r)
				3'h1: dref_nxt = rcnt_r[0];
				3'h2: dref_nxt = rcnt_r[1];
				3'h3: dref_nxt = rcnt_r[2];
				default: dref_nxt = rcnt_r[3];
			endcase
		end
		if (swrst_r) begin
			rcnt_nxt = 4'h0;
		end
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			srcp_r <= 1'b0;
			rcnt_r <= 4'h0;
			dref_r <= 1'b0;
		end else begin
			srcp_r <= srcp_nxt;
			rcnt_r <= rcnt_nxt;
			dref_r <= dref_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = perr_r;
	assign converter_enable_o = cen_r;
	assign dac_bit_o = dac_r;
	assign feedback_ratio_o = ratio_r;
	assign divided_ref_o = dref_r;
endmodule
`default_nettype wire

/* inc/tpl_pkg.sv */
// Package for the loop control block: register map, fields, reset values.
// Assumes APB with 32-bit data, one register per aligned word.
package tpl_pkg;
	// Byte addresses
	localparam logic [7:0] ADDR_CFG      = 8'h00;
	localparam logic [7:0] ADDR_FRAC     = 8'h04;
	localparam logic [7:0] ADDR_INT      = 8'h08;
	localparam logic [7:0] ADDR_FBMOD    = 8'h0c;
	localparam logic [7:0] ADDR_REFDIV   = 8'h10;
	localparam logic [7:0] ADDR_FILT     = 8'h14;
	localparam logic [7:0] ADDR_CTRL     = 8'h18;
	// Field positions: phase_loop_config, feedback modulator, control
	localparam int CFG_EN_BIT   = 15;
	localparam int KP_LSB       = 9;
	localparam int KI_LSB       = 4;
	localparam int FL_LSB       = 2;
	localparam int DORD_LSB     = 0;
	localparam int FBMOD_EN_BIT = 7;
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_SRC_BIT = 1;
	// Reset values
	localparam logic [4:0]  KP_RST     = 5'h0f;
	localparam logic [4:0]  KI_RST     = 5'h04;
	localparam logic [1:0]  FL_RST     = 2'h2;
	localparam logic [1:0]  DORD_RST   = 2'h2;
	localparam logic [15:0] FRAC_RST   = 16'h2800;
	localparam logic [7:0]  INT_RST    = 8'h24;
	localparam logic        FBEN_RST   = 1'b1;
	localparam logic [1:0]  FBORD_RST  = 2'h1;
	localparam logic [2:0]  REFDIV_RST = 3'h1;
	localparam logic        SWRST_RST  = 1'b0;
endpackage

/* bench/tpl_loop_ctrl_asserts.sv */
// Port checker for tpl_loop_ctrl: APB handshake and decode.
// Assumes the answer comes one cycle after the taken edge.
`timescale 1ns/100ps
`default_nettype none
module tpl_loop_ctrl_asserts (
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        converter_enable_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire logic acc = psel_i && penable_i && !pready_o;
	wire logic rd = acc && !pwrite_i;
	wire logic bad = paddr_i > 8'h18;
	wire logic wcfg = acc && pwrite_i && paddr_i == 8'h00;
	a_ready_next: assert property (acc |=> pready_o) else $error("no ready");
	a_ready_once: assert property (pready_o |=> !pready_o) else $error("ready held");
	a_ready_cause: assert property (pready_o |-> $past(acc)) else $error("stray ready");
	a_err_ready: assert property (pslverr_o |-> pready_o) else $error("lone error");
	a_err_unmapped: assert property (acc && bad |=> pslverr_o) else $error("no error");
	a_unmapped_zero: assert property (rd && bad |=> prdata_o == 32'h0) else $error("bad data");
	a_status_width: assert property (rd && paddr_i == 8'h14 |=> prdata_o[31:16] == 16'h0)
		else $error("status upper bits");
	// A slower output flop is tolerated, hence two cycles back
	a_enable_cause: assert property (!$stable(converter_enable_o) |-> $past(wcfg) || $past(wcfg, 2))
		else $error("enable moved alone");
	c_write: cover property (wcfg);
	c_unmapped: cover property (acc && bad);
	c_status: cover property (rd && paddr_i == 8'h14);
endmodule
bind tpl_loop_ctrl tpl_loop_ctrl_asserts u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.converter_enable_o(converter_enable_o));
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for tpl_loop_ctrl, driven over APB.
// Assumes the port checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk = 1'b0, rn = 1'b0, ps = 1'b0, pe = 1'b0, pw = 1'b0, e, s = 1'b0;
	logic        up = 1'b0, dn = 1'b0, xo = 1'b0, ri = 1'b0, xr = 1'b0, rr = 1'b0;
	logic        prdy, perr, cen, dref, dac;
	logic [7:0]  pa = 8'h0, fr;
	logic [31:0] wd = 32'h0, prd, rd;
	logic [3:0]  cy = 4'h0;
	int          n_fail = 0, comparisons = 0;
	always #10 clk = ~clk;
	// Slow input clocks of different rates show which source is picked
	always @(posedge clk) begin
		cy <= cy + 4'h1;
		xo <= xr & cy[2];
		ri <= rr & cy[3];
	end
	tpl_loop_ctrl dut (.ref_clk_i(clk), .reset_n_i(rn), .psel_i(ps), .penable_i(pe),
		.pwrite_i(pw), .paddr_i(pa), .pwdata_i(wd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .phase_up_i(up), .phase_down_i(dn), .xo_clk_i(xo),
		.ref_in_clk_i(ri), .converter_enable_o(cen), .dac_bit_o(dac),
		.feedback_ratio_o(fr), .divided_ref_o(dref));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, g, x);
		end
	endtask
	task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		ps <= 1'b1;
		pw <= w;
		pa <= a;
		wd <= d;
		@(posedge clk);
		pe <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1 && ++k < 40);
		rd = prd;
		e = perr;
		ps <= 1'b0;
		pe <= 1'b0;
		@(posedge clk);
		chk({31'h0, k < 40}, 1);
	endtask
	task automatic prog(input logic [7:0] a, input logic [31:0] d);
		io(1, 8'h18, {30'h0, s, 1'b1});
		io(1, a, d);
		io(1, 8'h18, {30'h0, s, 1'b0});
	endtask
	task automatic t_reset;
		logic [31:0] x [7] = '{32'h1e4a, 32'h2800, 32'h24, 32'h81, 32'h1, 32'h0, 32'h0};
		chk({24'h0, fr}, 32'h24);
		for (int i = 0; i < 7; i++) begin
			io(0, 8'(i * 4), 0);
			chk(rd, x[i]);
		end
	endtask
	task automatic t_rw;
		logic [31:0] x [7] = '{32'hbff4, 32'hfff4, 32'hf4, 32'h80, 32'h4, 32'h0, 32'h0};
		for (int i = 0; i < 7; i++) begin
			io(1, 8'(i * 4), 32'hffff_fff4);
			io(0, 8'(i * 4), 0);
			chk(rd, x[i]);
		end
		chk({31'h0, cen}, 1);
		io(0, 8'h1c, 0);
		chk(rd, 0);
		chk({31'h0, e}, 1);
	endtask
	task automatic t_ratio;
		int h, b;
		h = 0;
		b = 0;
		xr <= 1'b1;
		prog(8'h10, 32'h1);
		prog(8'h08, 32'h37);
		prog(8'h0c, 32'h0);
		prog(8'h04, 32'h4000);
		repeat (600) begin
			@(posedge clk);
			if (fr !== 8'h37) b++;
		end
		chk(b, 0);
		prog(8'h0c, 32'h81);
		repeat (600) begin
			@(posedge clk);
			if (fr === 8'h38) h++;
			else if (fr !== 8'h37) b++;
		end
		chk(b, 0);
		chk({31'h0, h > 0}, 1);
	endtask
	task automatic t_div(input logic src, input logic [2:0] c, input int x);
		int n;
		logic p;
		s = src;
		prog(8'h10, {29'h0, c});
		n = 0;
		p = dref;
		repeat (1024) begin
			@(posedge clk);
			n += int'(dref & !p);
			p = dref;
		end
		chk({31'h0, n >= x - 1 && n <= x + 1}, 1);
	endtask
	task automatic t_pulse(input logic [15:0] cf, input int n, input logic d,
		input logic [15:0] x);
		prog(8'h00, {16'h0, cf});
		up <= d;
		dn <= !d;
		repeat (n) @(posedge clk);
		up <= 1'b0;
		dn <= 1'b0;
		repeat (12) @(posedge clk);
		io(0, 8'h14, 0);
		chk(rd, {16'h0, x});
	endtask
	// Read while the error still stands: proportional term of 2^8 must show
	task automatic t_prop;
		prog(8'h00, 32'h1002);
		up <= 1'b1;
		repeat (10) @(posedge clk);
		io(0, 8'h14, 0);
		up <= 1'b0;
		chk({31'h0, rd[15:0] > 16'h0100 && rd[15:0] < 16'h0110}, 1);
	endtask
	// Zero filter output is midscale: half ones for a first-order modulator
	task automatic t_dac(input logic [1:0] o, input int x);
		int n;
		prog(8'h00, {30'h0, o});
		n = 0;
		repeat (64) begin
			@(posedge clk);
			n += int'(dac);
		end
		chk({31'h0, n >= x - 1 && n <= x + 1}, 1);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_rw;
		t_ratio;
		for (int c = 0; c < 5; c++) t_div(0, 3'(c), 128 >> c);
		rr <= 1'b1;
		t_div(1, 3'h1, 32);
		t_prop;
		// One-cycle pulses are filtered by the pin synchroniser, so hold two
		t_pulse(16'h0612, 2, 1, 16'h4);
		t_pulse(16'h0612, 2, 0, 16'hfffc);
		// Railed from the fifth sample on: four plain steps, then one boosted
		for (int f = 0; f < 4; f++) t_pulse(16'(32'h612 | (f << 2)), 5, 1,
			16'(8 + (2 << (2 * f))));
		t_dac(2'h0, 64);
		t_dac(2'h1, 32);
		t_dac(2'h3, 0);
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end
endmodule
`default_nettype wire
